/* sim/dos_ctrl_tb.sv */
// Self-checking bench for dos_ctrl: register port, lock, output states, port copies.
// Assumes dos_ser_model as the far side; short lock and idle counts keep the run brief.
`timescale 1ns/1ns
module dos_ctrl_tb;
   import dos_pkg::*;
   localparam int LCK = 4;
   localparam int IDL = 3;
   logic        mclk, rst_n, power_down_n, osc_tick, run, scl_i, m_sda;
   logic        emb_clk_edge, sda_o, sda_oe_n, lock_o, lock_oe_n, par_oe_n, lvds_oe_n;
   logic [23:0] rx_par_data, par_o;
   logic [7:0]  rx_lvds_data, lvds_d_o, rd_v;
   logic [1:0]  rx_lvds_clk, lvds_clk_o;
   logic [1:0]  port_cfg_o [2];
   wire         sda_i;
   int          num_errors, checks_done, cyc;
   // Open-drain wire: the target pulls low when its enable is low
   assign sda_i = m_sda & sda_oe_n;
   dos_ser_model dos_ser_model_inst (.mclk(mclk), .run(run), .emb_clk_edge(emb_clk_edge),
      .rx_par_data(rx_par_data), .rx_lvds_data(rx_lvds_data), .rx_lvds_clk(rx_lvds_clk));
   dos_ctrl #(.LOCK_CYC(LCK), .IDLE_CYC(IDL)) dos_ctrl_inst (.mclk(mclk), .rst_n(rst_n),
      .power_down_n(power_down_n), .emb_clk_edge(emb_clk_edge), .osc_tick(osc_tick),
      .rx_par_data(rx_par_data), .rx_lvds_data(rx_lvds_data), .rx_lvds_clk(rx_lvds_clk),
      .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .lock_o(lock_o),
      .lock_oe_n(lock_oe_n), .par_o(par_o), .par_oe_n(par_oe_n), .lvds_d_o(lvds_d_o),
      .lvds_clk_o(lvds_clk_o), .lvds_oe_n(lvds_oe_n), .port_cfg_o(port_cfg_o));
   // ------------------------------------------------------------
   // Clock, oscillator, timeout
   // ------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      osc_tick <= #1 ~osc_tick;
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         close_out();
      end
   end
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic tick(int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : tick
   task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s expected %0h seen %0h", nm, exp, got);
      end
   endtask : chk
   task automatic bit_out(logic b);
      m_sda = b;
      tick(2);
      scl_i = 1'b1;
      tick(2);
      scl_i = 1'b0;
      tick(3);
   endtask : bit_out
   task automatic start_c;
      m_sda = 1'b1;
      tick(2);
      scl_i = 1'b1;
      tick(2);
      m_sda = 1'b0;
      tick(2);
      scl_i = 1'b0;
      tick(3);
   endtask : start_c
   task automatic stop_c;
      m_sda = 1'b0;
      tick(2);
      scl_i = 1'b1;
      tick(2);
      m_sda = 1'b1;
      tick(3);
   endtask : stop_c
   task automatic byte_out(logic [7:0] b, logic ack);
      logic got;
      for (int i = 7; i >= 0; i--) bit_out(b[i]);
      m_sda = 1'b1;
      tick(2);
      scl_i = 1'b1;
      tick(1);
      got = sda_i;
      tick(1);
      scl_i = 1'b0;
      tick(3);
      chk("ack", !ack, got);
   endtask : byte_out
   task automatic wr(logic [7:0] a, logic [7:0] d);
      start_c();
      byte_out({DEV_ADDR_DEF, 1'b0}, 1'b1);
      byte_out(a, 1'b1);
      byte_out(d, 1'b1);
      stop_c();
   endtask : wr
   task automatic rd(logic [7:0] a, output logic [7:0] d);
      start_c();
      byte_out({DEV_ADDR_DEF, 1'b0}, 1'b1);
      byte_out(a, 1'b1);
      start_c();
      byte_out({DEV_ADDR_DEF, 1'b1}, 1'b1);
      m_sda = 1'b1;
      for (int i = 7; i >= 0; i--) begin
         scl_i = 1'b1;
         tick(1);
         d[i] = sda_i;
         tick(1);
         scl_i = 1'b0;
         tick(3);
      end
      bit_out(1'b1);
      stop_c();
   endtask : rd
   task automatic wait_lock(logic want);
      int n;
      n = 0;
      while (lock_o !== want && n < 40) begin
         tick(1);
         n++;
      end
      chk("lock_o", want, lock_o);
   endtask : wait_lock
   task automatic all_low;
      chk("lock", 0, {lock_oe_n, lock_o});
      chk("par", 0, {par_oe_n, par_o});
      chk("lvds", 0, {lvds_oe_n, lvds_d_o, lvds_clk_o});
   endtask : all_low
   task automatic count_clk(output int n);
      logic [1:0] p;
      n = 0;
      p = lvds_clk_o;
      repeat (8) begin
         tick(1);
         if (lvds_clk_o !== p) n++;
         p = lvds_clk_o;
      end
   endtask : count_clk
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      chk("lock", 0, {lock_oe_n, lock_o});
      chk("sda_o", 0, sda_o);
      rd(REG_GEN_CFG, rd_v);
      chk("gen_cfg", GEN_CFG_RST, rd_v);
      rd(REG_PORT_SEL, rd_v);
      chk("port_sel", PSEL_RST, rd_v);
      rd(8'h50, rd_v);
      chk("unmapped", 0, rd_v);
      start_c();
      byte_out({DEV_ADDR_DEF ^ 7'h01, 1'b0}, 1'b0);
      stop_c();
      $display("test reset done");
   endtask : t_reset
   task automatic t_lock;
      logic [23:0] d;
      logic [9:0]  l;
      run = 1'b1;
      wait_lock(1'b1);
      d = rx_par_data;
      l = {rx_lvds_data, rx_lvds_clk};
      tick(1);
      chk("par_o", {1'b0, d}, {par_oe_n, par_o});
      chk("lvds_o", {1'b0, l}, {lvds_oe_n, lvds_d_o, lvds_clk_o});
      wr(REG_GEN_CFG, 8'h10);
      tick(2);
      chk("oe_off_lock", 3'h7, {lock_o, par_oe_n, lvds_oe_n});
      wr(REG_GEN_CFG, 8'h00);
      tick(2);
      all_low();
      wr(REG_GEN_CFG, 8'h80);
      tick(2);
      all_low();
      $display("test lock done");
   endtask : t_lock
   task automatic t_loss;
      int n;
      wr(REG_GEN_CFG, 8'h90);
      wait_lock(1'b1);
      run = 1'b0;
      wait_lock(1'b0);
      tick(1);
      all_low();
      wr(REG_GEN_CFG, 8'hA0);
      tick(2);
      count_clk(n);
      chk("fb_toggles", 4, n);
      chk("par", 0, {par_oe_n, par_o});
      wr(REG_GEN_CFG, 8'h80);
      tick(2);
      count_clk(n);
      chk("fb_off", 0, n);
      all_low();
      $display("test loss done");
   endtask : t_loss
   task automatic t_ports;
      wr(REG_PORT_SEL, 8'h01);
      wr(REG_PORT_CFG, 8'h01);
      wr(REG_PORT_SEL, 8'h02);
      wr(REG_PORT_CFG, 8'h02);
      chk("copies", 4'h9, {port_cfg_o[1], port_cfg_o[0]});
      rd(REG_PORT_CFG, rd_v);
      chk("rd_second", 2, rd_v);
      wr(REG_PORT_SEL, 8'h01);
      rd(REG_PORT_CFG, rd_v);
      chk("rd_first", 1, rd_v);
      wr(REG_PORT_SEL, 8'h03);
      rd(REG_PORT_CFG, rd_v);
      chk("rd_both", 2, rd_v);
      rd(REG_GEN_CFG, rd_v);
      chk("shared", 8'h80, rd_v);
      wr(REG_PORT_CFG, 8'h03);
      chk("copies_both", 4'hF, {port_cfg_o[1], port_cfg_o[0]});
      wr(REG_PORT_SEL, 8'h00);
      wr(REG_PORT_CFG, 8'h00);
      chk("copies_none", 4'hF, {port_cfg_o[1], port_cfg_o[0]});
      rd(REG_PORT_CFG, rd_v);
      chk("rd_none", 3, rd_v);
      $display("test ports done");
   endtask : t_ports
   task automatic t_pd;
      run = 1'b1;
      power_down_n = 1'b0;
      tick(2);
      chk("oe_n", 3'h7, {lock_oe_n, par_oe_n, lvds_oe_n});
      power_down_n = 1'b1;
      tick(1);
      chk("lock", 0, {lock_oe_n, lock_o});
      rd(REG_GEN_CFG, rd_v);
      chk("gen_cfg", GEN_CFG_RST, rd_v);
      $display("test power down done");
   endtask : t_pd
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : close_out
   initial begin
      rst_n = 1'b0;
      power_down_n = 1'b1;
      osc_tick = 1'b0;
      run = 1'b0;
      scl_i = 1'b1;
      m_sda = 1'b1;
      num_errors = 0;
      checks_done = 0;
      cyc = 0;
      tick(5);
      rst_n = 1'b1;
      tick(1);
      t_reset();
      t_lock();
      t_loss();
      t_ports();
      t_pd();
      close_out();
   end
endmodule : dos_ctrl_tb

/* sim/dos_ser_model.sv */
// Stand-in for the paired serializer: embedded clock edges and recovered streams.
// Assumes mclk from the bench; run high means a live serial input, low a static one.
`timescale 1ns/1ns
module dos_ser_model (
   input  wire logic   mclk,
   input  wire logic   run,
   output logic        emb_clk_edge,
   output logic [23:0] rx_par_data,
   output logic [7:0]  rx_lvds_data,
   output logic [1:0]  rx_lvds_clk
);
   logic [7:0] cnt_q;
   initial begin
      cnt_q = 8'h00;
      emb_clk_edge = 1'b0;
      rx_par_data = 24'h000000;
      rx_lvds_data = 8'h00;
      rx_lvds_clk = 2'h0;
   end
   // ------------------------------------------------------------
   // Stream
   // ------------------------------------------------------------
   // Idle lines flip every cycle so a stale value never passes for data
   // Updates land on the edge itself, so a read 1 ns later sees what the design samples next
   always @(posedge mclk) begin
      cnt_q <= cnt_q + 8'h01;
      emb_clk_edge <= run & cnt_q[0];
      rx_par_data <= run ? {3{cnt_q ^ 8'hA5}} : ~rx_par_data;
      rx_lvds_data <= run ? cnt_q : ~rx_lvds_data;
      rx_lvds_clk <= run ? {2{cnt_q[1]}} : ~rx_lvds_clk;
   end
endmodule : dos_ser_model

/* src/dos_ctrl.sv */
// Output-state control, fallback clock, port-select registers and serial control target.
// Assumes scl/sda and all link inputs are synchronous to mclk; sda is open drain, pad outside.
`timescale 1ns/1ns
//
// Operation
// - After power-down release, start locking; lock pin low or floating per output enable; lock_oe_n stays low here outside reset and power-down.
// - When the lock sequence completes, drive lock high, outputs valid.
// - Lock from embedded clock alone, no reference, any data pattern.
// - Power-down low floats lock, parallel and LVDS outputs regardless of settings.
// - Output enable clear: sleep 0 drives all low; sleep 1 lock shows link, rest float.
// - Enabled, static input: lock and parallel low; LVDS low or oscillator per sleep.
// - Enabled, active input: sleep 1 gives valid outputs; sleep 0 holds all low.
// - Without input clock, oscillator clock may be driven on LVDS clock pairs.
// - Fallback clock gated by bit 5 of register general_output_config.
// - Two per-port register copies chosen by select bits 1:0 at 0x34.
// - Shared registers reachable whatever the port select bits hold.
// - Reads return selected copy; both bits set returns the second port copy.
// - Writes update every copy whose select bit is set.
// - Registers programmed through an I2C-compatible target port.
module dos_ctrl
   import dos_pkg::*;
#(
   parameter int         PAR_W    = 24,
   parameter int         LOCK_CYC = dos_pkg::LOCK_CYC_DEF,
   parameter int         IDLE_CYC = dos_pkg::IDLE_CYC_DEF,
   parameter logic [6:0] DEV_ADDR = dos_pkg::DEV_ADDR_DEF
) (
   input  wire logic             mclk,
   input  wire logic             rst_n,
   input  wire logic             power_down_n,
   input  wire logic             emb_clk_edge,
   input  wire logic             osc_tick,
   input  wire logic [PAR_W-1:0] rx_par_data,
   input  wire logic [7:0]       rx_lvds_data,
   input  wire logic [1:0]       rx_lvds_clk,
   input  wire logic             scl_i,
   input  wire logic             sda_i,
   output logic                  sda_o,
   output logic                  sda_oe_n,
   output logic                  lock_o,
   output logic                  lock_oe_n,
   output logic [PAR_W-1:0]      par_o,
   output logic                  par_oe_n,
   output logic [7:0]            lvds_d_o,
   output logic [1:0]            lvds_clk_o,
   output logic                  lvds_oe_n,
   output logic [1:0]            port_cfg_o [2]
);
   // ------------------------------------------------------------
   // Lock sequence
   // ------------------------------------------------------------
   logic link_active;
   logic link_locked;
   wire  run = rst_n & power_down_n;
   if (PAR_W < 1 || PAR_W > 64) begin : g_bad
      $error("dos_ctrl: PAR_W out of range");
   end

   dos_lock_seq #(.LOCK_CYC(LOCK_CYC), .IDLE_CYC(IDLE_CYC)) u_lock (
      .mclk         (mclk),
      .rst_n        (rst_n),
      .power_down_n (power_down_n),
      .emb_clk_edge (emb_clk_edge),
      .link_active  (link_active),
      .link_locked  (link_locked)
   );

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [7:0] gen_cfg_q;
   logic [1:0] psel_q;
   logic [7:0] pcfg_q [2];
   logic       wr_stb;
   logic [7:0] ptr_q;
   logic [7:0] sh_q;
   logic [7:0] rd_data;
   wire        oe_en   = gen_cfg_q[GEN_OE_BIT];
   wire        sleep   = gen_cfg_q[GEN_SLEEP_BIT];
   wire        fb_en   = gen_cfg_q[GEN_FBCLK_BIT];
   wire        hit_gen = ptr_q == REG_GEN_CFG;
   wire        hit_ps  = ptr_q == REG_PORT_SEL;
   wire        hit_pc  = ptr_q == REG_PORT_CFG;
   wire        hit_st  = ptr_q == REG_LINK_STAT;
   // Second copy wins when both picks are set; no pick reads the first copy
   wire [7:0]  pcfg_rd = psel_q[SECOND_PICK] ? pcfg_q[1] : pcfg_q[0];

   // Shared registers decode without looking at the picks
   assign rd_data = hit_gen ? gen_cfg_q :
                    hit_ps  ? {6'h00, psel_q} :
                    hit_st  ? {6'h00, link_active, link_locked} :
                    hit_pc  ? pcfg_rd : 8'h00;

   always_ff @(posedge mclk) begin
      if (!run) begin
         gen_cfg_q <= GEN_CFG_RST;
         psel_q    <= PSEL_RST;
      end else if (wr_stb && hit_gen) begin
         gen_cfg_q <= sh_q;
      end else if (wr_stb && hit_ps) begin
         psel_q    <= sh_q[1:0];
      end
   end

   always_ff @(posedge mclk) begin
      for (int p = 0; p < 2; p++) begin
         if (!run) begin
            pcfg_q[p] <= PORT_CFG_RST;
         end else if (wr_stb && hit_pc && psel_q[p]) begin
            pcfg_q[p] <= sh_q;
         end
      end
   end
   assign port_cfg_o = '{pcfg_q[0][1:0], pcfg_q[1][1:0]};

   // ------------------------------------------------------------
   // Serial control target
   // ------------------------------------------------------------
   dos_state_e st_q;
   dos_state_e st_d;
   logic       scl_q;
   logic       sda_q;
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic [7:0] sh_d;
   logic [7:0] tx_q;
   logic [7:0] tx_d;
   logic [7:0] ptr_d;
   logic       first_q;
   logic       first_d;
   logic       rw_q;
   logic       rw_d;
   logic       drv_q;
   logic       drv_d;
   wire        rise   = scl_i & ~scl_q;
   wire        fall   = ~scl_i & scl_q;
   wire        start  = scl_i & scl_q & sda_q & ~sda_i;
   wire        stop   = scl_i & scl_q & ~sda_q & sda_i;
   wire        byte_f = fall && (cnt_q == 4'h8);
   wire [2:0]  tx_idx = 3'(4'h7 - cnt_q);

   assign wr_stb   = (st_q == ST_WRX) && byte_f && !first_q;
   assign sda_o    = 1'b0;
   assign sda_oe_n = ~drv_q;

   always_comb begin
      st_d    = st_q;
      cnt_d   = rise ? cnt_q + 4'h1 : cnt_q;
      sh_d    = rise ? {sh_q[6:0], sda_i} : sh_q;
      tx_d    = tx_q;
      ptr_d   = ptr_q;
      first_d = first_q;
      rw_d    = rw_q;
      drv_d   = drv_q;
      if (start) begin
         st_d    = ST_ADDR;
         cnt_d   = 4'h0;
         first_d = 1'b1;
         drv_d   = 1'b0;
      end else if (stop) begin
         st_d  = ST_IDLE;
         drv_d = 1'b0;
      end else if (fall) begin
         case (st_q)
            ST_ADDR: begin
               if (cnt_q == 4'h8) begin
                  cnt_d = 4'h0;
                  rw_d  = sh_q[0];
                  drv_d = sh_q[7:1] == DEV_ADDR;
                  st_d  = (sh_q[7:1] == DEV_ADDR) ? ST_AACK : ST_IDLE;
               end
            end
            ST_AACK, ST_RACK: begin
               cnt_d = 4'h0;
               if (rw_q && (st_q == ST_AACK || !sh_q[0])) begin
                  tx_d  = rd_data;
                  drv_d = ~rd_data[7];
                  st_d  = ST_RTX;
               end else begin
                  drv_d = 1'b0;
                  st_d  = rw_q ? ST_IDLE : ST_WRX;
               end
            end
            ST_WRX: begin
               if (cnt_q == 4'h8) begin
                  cnt_d   = 4'h0;
                  first_d = 1'b0;
                  ptr_d   = first_q ? sh_q : ptr_q + 8'h01;
                  drv_d   = 1'b1;
                  st_d    = ST_WACK;
               end
            end
            ST_WACK: begin
               cnt_d = 4'h0;
               drv_d = 1'b0;
               st_d  = ST_WRX;
            end
            ST_RTX: begin
               if (cnt_q == 4'h8) begin
                  cnt_d = 4'h0;
                  drv_d = 1'b0;
                  ptr_d = ptr_q + 8'h01;
                  st_d  = ST_RACK;
               end else begin
                  drv_d = ~tx_q[tx_idx];
               end
            end
            default: st_d = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!run) begin
         st_q    <= ST_IDLE;
         scl_q   <= 1'b1;
         sda_q   <= 1'b1;
         cnt_q   <= 4'h0;
         sh_q    <= 8'h00;
         tx_q    <= 8'h00;
         ptr_q   <= 8'h00;
         first_q <= 1'b1;
         rw_q    <= 1'b0;
         drv_q   <= 1'b0;
      end else begin
         st_q    <= st_d;
         scl_q   <= scl_i;
         sda_q   <= sda_i;
         cnt_q   <= cnt_d;
         sh_q    <= sh_d;
         tx_q    <= tx_d;
         ptr_q   <= ptr_d;
         first_q <= first_d;
         rw_q    <= rw_d;
         drv_q   <= drv_d;
      end
   end

   // ------------------------------------------------------------
   // Output state decision
   // ------------------------------------------------------------
   logic osc_q;
   wire  valid_out = oe_en & sleep & link_locked;
   // Oscillator only stands in while the link clock is gone
   wire  fb_drive  = oe_en & ~sleep & fb_en & ~link_active;
   wire  lock_d    = ~oe_en ? (sleep & link_locked) : (sleep & link_locked);
   wire  lock_oen_d = 1'b0;
   wire  par_oen_d  = ~oe_en & sleep;
   wire  [1:0] ck_d = valid_out ? rx_lvds_clk : (fb_drive ? {2{osc_q}} : 2'h0);

   always_ff @(posedge mclk) begin
      if (!run) begin
         osc_q      <= 1'b0;
         lock_o     <= 1'b0;
         lock_oe_n  <= 1'b1;
         par_o      <= '0;
         par_oe_n   <= 1'b1;
         lvds_d_o   <= 8'h00;
         lvds_clk_o <= 2'h0;
         lvds_oe_n  <= 1'b1;
      end else begin
         osc_q      <= osc_q ^ osc_tick;
         lock_o     <= lock_d;
         lock_oe_n  <= lock_oen_d;
         par_o      <= valid_out ? rx_par_data : '0;
         par_oe_n   <= par_oen_d;
         lvds_d_o   <= valid_out ? rx_lvds_data : 8'h00;
         lvds_clk_o <= ck_d;
         lvds_oe_n  <= par_oen_d;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!run);
   sequence s_valid_cfg;
      oe_en && sleep && link_locked;
   endsequence
   a_pd_float_all : assert property (@(posedge mclk) disable iff (!rst_n)
      !power_down_n |=> lock_oe_n && par_oe_n && lvds_oe_n) else $error("outputs not floated in power-down");
   a_lock_high : assert property (s_valid_cfg |=> lock_o && !lock_oe_n) else $error("lock not driven high");
   a_par_valid : assert property (s_valid_cfg |=> par_o == $past(rx_par_data))
      else $error("parallel data not passed");
   a_sleep0_low : assert property (!sleep |=> !lock_o && par_o == '0 && lvds_d_o == 8'h00)
      else $error("sleep 0 outputs not low");
   a_off_float : assert property (!oe_en && sleep |=> par_oe_n && lvds_oe_n) else $error("not floating");
   a_static_low : assert property (oe_en && !link_locked |=> !lock_o && par_o == '0)
      else $error("static input outputs not low");
   a_fb_gate : assert property (!fb_en && !valid_out |=> lvds_clk_o == 2'h0) else $error("clock leaks");
   a_dup_write : assert property (wr_stb && hit_pc && psel_q == 2'h3 |=> pcfg_q[0] == pcfg_q[1])
      else $error("both copies not written");
   a_dup_read : assert property (hit_pc && psel_q[SECOND_PICK] |-> rd_data == pcfg_q[1])
      else $error("second copy not read");
   a_lock_drop : assert property (oe_en && sleep && lock_o ##1 !link_locked |=> !lock_o)
      else $error("lock indicator held after loss");
endmodule : dos_ctrl

/* src/dos_lock_seq.sv */
// Link activity detection and lock sequence for the recovered embedded clock.
// Assumes emb_clk_edge marks each embedded clock edge seen by clock recovery, synchronous to mclk.
`timescale 1ns/1ns
module dos_lock_seq #(
   parameter int LOCK_CYC = dos_pkg::LOCK_CYC_DEF,
   parameter int IDLE_CYC = dos_pkg::IDLE_CYC_DEF
) (
   input  wire logic mclk,
   input  wire logic rst_n,
   input  wire logic power_down_n,
   input  wire logic emb_clk_edge,
   output logic      link_active,
   output logic      link_locked
);
   import dos_pkg::*;

   logic [15:0] idle_q;
   logic [15:0] idle_d;
   logic [15:0] lock_cnt_q;
   logic [15:0] lock_cnt_d;
   logic        locked_q;
   logic        locked_d;
   wire         run = rst_n & power_down_n;

   if (LOCK_CYC < 2 || LOCK_CYC > 65535 || IDLE_CYC < 2 || IDLE_CYC > 65535) begin : g_bad
      $error("dos_lock_seq: counts out of range");
   end

   // Only the embedded clock edges are watched, so any data pattern locks
   assign idle_d      = emb_clk_edge ? 16'h0000 : ((idle_q < 16'(IDLE_CYC)) ? idle_q + 16'h0001 : idle_q);
   assign link_active = idle_q < 16'(IDLE_CYC);
   assign lock_cnt_d  = !link_active ? 16'h0000 :
                        ((lock_cnt_q < 16'(LOCK_CYC)) ? lock_cnt_q + 16'h0001 : lock_cnt_q);
   // Losing activity drops lock on the next cycle
   assign locked_d    = link_active && (lock_cnt_q == 16'(LOCK_CYC));
   assign link_locked = locked_q;

   always_ff @(posedge mclk) begin
      if (!run) begin
         idle_q     <= 16'(IDLE_CYC);
         lock_cnt_q <= 16'h0000;
         locked_q   <= 1'b0;
      end else begin
         idle_q     <= idle_d;
         lock_cnt_q <= lock_cnt_d;
         locked_q   <= locked_d;
      end
   end

   a_lock_needs_act : assert property (@(posedge mclk) disable iff (!run)
      link_locked |-> $past(link_active)) else $error("lock held without activity");
endmodule : dos_lock_seq

/* src/dos_pkg.sv */
// Shared constants for the deserializer output-state and port-select control block.
// Assumes a single 100 MHz clock domain and byte-wide registers on the serial control port.
package dos_pkg;
   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] REG_GEN_CFG   = 8'h02;
   localparam logic [7:0] REG_PORT_SEL  = 8'h34;
   localparam logic [7:0] REG_LINK_STAT = 8'h1C;
   localparam logic [7:0] REG_PORT_CFG  = 8'h1D;
   // ------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------
   localparam int         GEN_OE_BIT    = 7;
   localparam int         GEN_FBCLK_BIT = 5;
   localparam int         GEN_SLEEP_BIT = 4;
   localparam int         FIRST_PICK    = 0;
   localparam int         SECOND_PICK   = 1;
   localparam logic [7:0] GEN_CFG_RST   = 8'h90;
   localparam logic [1:0] PSEL_RST      = 2'h1;
   localparam logic [7:0] PORT_CFG_RST  = 8'h00;
   localparam logic [6:0] DEV_ADDR_DEF  = 7'h2C; // Arbitrary target address
   // ------------------------------------------------------------
   // Timing counts in mclk cycles
   // ------------------------------------------------------------
   localparam int         LOCK_CYC_DEF  = 64;
   localparam int         IDLE_CYC_DEF  = 16;
   // ------------------------------------------------------------
   // Control port states
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ADDR = 3'h1,
      ST_AACK = 3'h3,
      ST_WRX  = 3'h2,
      ST_WACK = 3'h6,
      ST_RTX  = 3'h7,
      ST_RACK = 3'h5
   } dos_state_e;
endpackage : dos_pkg
